// *** core/pvd_pkg.sv ***
// Constants and types for the power-on-clear and low-voltage detector control block
// Behaviour
// R1: Single-threshold mode: reset until supply above low level
// R2: Dual mode: reset below low, release above upper
// R3: Fast rise in dual mode inserts stabilisation wait
// R4: Source select picks supply or external pin comparator
// R5: Reset action holds reset while selected level low
// R6: Interrupt action fires on both threshold crossings
// R7: Software picks one of sixteen detection levels
// R8: Detector keeps working during stop mode
// R9: Control bit 0 reads current below-threshold flag
// R10: Detector reset sets reset-source bit 0
// R11: Source select bit 2, action bit 1
// R12: Control register bit or byte writable, resets zero
// R13: Control bits survive detector reset, cleared otherwise
// R14: Comparator runs only while enable bit set
// R15: Enabled interrupt action drives flag as request
// R16: Comparator outputs synchronised before any use
package pvd_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [15:0] PVD_ADDR_CTRL   = 16'hFFBE;
  localparam logic [15:0] PVD_ADDR_LEVEL  = 16'hFFBF;
  localparam logic [15:0] PVD_ADDR_RSTSRC = 16'hFFA8;

  localparam int unsigned PVD_CTRL_EN_BIT   = 7;
  localparam int unsigned PVD_CTRL_SEL_BIT  = 2;
  localparam int unsigned PVD_CTRL_ACT_BIT  = 1;
  localparam int unsigned PVD_CTRL_FLAG_BIT = 0;
  localparam int unsigned PVD_RSTSRC_LV_BIT = 0;

  localparam logic [7:0] PVD_CTRL_RESET   = 8'h00;
  localparam logic [3:0] PVD_LEVEL_RESET  = 4'h0;
  localparam logic [7:0] PVD_RDATA_RESET  = 8'h00;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned PVD_CLK_MHZ        = 200;
  localparam int unsigned PVD_SHORT_WINDOW_US_X100 = 193;
  localparam int unsigned PVD_STAB_WAIT_US_X100    = 539;
  // 1.93 ms and 5.39 ms in units of 10 us, times 10 us worth of cycles
  localparam int unsigned PVD_SHORT_WINDOW_CYC =
    PVD_SHORT_WINDOW_US_X100 * 10 * PVD_CLK_MHZ;
  localparam int unsigned PVD_STAB_WAIT_CYC =
    PVD_STAB_WAIT_US_X100 * 10 * PVD_CLK_MHZ;

  localparam int unsigned PVD_CNT_W = 21;
  typedef logic [PVD_CNT_W-1:0] pvd_cnt_type;

  // ----------------------------------------------------------------
  // Power-on-clear states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    PVD_POC_HOLD = 3'b001,
    PVD_POC_STAB = 3'b010,
    PVD_POC_RUN  = 3'b100
  } pvd_poc_state_type;

endpackage : pvd_pkg

// *** core/pvd_sync_if.sv ***
// Carrier between an asynchronous comparator level and its synchroniser
`timescale 1ns/1ps
interface pvd_sync_if;
  logic raw;
  logic level;
  modport src (output raw, input level);
  modport snk (input raw, output level);
endinterface : pvd_sync_if

// *** core/pvd_sync.sv ***
// Three-stage synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
module pvd_sync (
  input  wire logic   i_clk_sys,
  input  wire logic   i_reset,
  input  wire logic   i_ce,
  pvd_sync_if.snk     sif
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
  } pvd_sync_state_type;

  pvd_sync_state_type st_ff;
  pvd_sync_state_type nxt_st;

  always_comb
  begin
    nxt_st       = st_ff;
    nxt_st.s1    = sif.raw;
    nxt_st.s2    = st_ff.s1;
    nxt_st.s3    = st_ff.s2;
    if (st_ff.s2 == st_ff.s3)
    begin
      nxt_st.level = st_ff.s3; // [R16]
    end
  end

  // Reset to zero reads as below threshold, the safe side
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      st_ff <= '0;
    end
    else if (i_ce)
    begin
      st_ff <= nxt_st;
    end
  end

  assign sif.level = st_ff.level;

endmodule : pvd_sync

// *** core/pvd_top.sv ***
// Power-on-clear reset sequencing and low-voltage detector control
`timescale 1ns/1ps
module pvd_top #(
  parameter int unsigned SHORT_WINDOW_CYC = pvd_pkg::PVD_SHORT_WINDOW_CYC,
  parameter int unsigned STAB_WAIT_CYC    = pvd_pkg::PVD_STAB_WAIT_CYC
) (
  input  wire logic        i_clk_sys,
  input  wire logic        i_reset,
  input  wire logic        i_ce,
  input  wire logic        i_poweron_threshold_mode,
  input  wire logic        i_supply_above_poc_low,
  input  wire logic        i_supply_above_poc_upper,
  input  wire logic        i_supply_above_detect,
  input  wire logic        i_ext_pin_above_detect,
  input  wire logic        i_wdt_reset,
  input  wire logic [15:0] i_reg_addr,
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_bit_wr,
  input  wire logic [2:0]  i_reg_bit_idx,
  input  wire logic        i_reg_bit_val,
  input  wire logic [7:0]  i_reg_wdata,
  input  wire logic        i_reg_rd,
  output logic [7:0]       o_reg_rdata,
  output logic             o_reg_rvalid,
  output logic             o_internal_reset,
  output logic             o_low_voltage_irq,
  output logic             o_irq_request,
  output logic             o_detector_enable,
  output logic             o_detect_source_select,
  output logic [3:0]       o_detect_level_select
);

  localparam int unsigned NSYNC = 5;

  typedef struct packed {
    pvd_pkg::pvd_poc_state_type poweron_clear;
    pvd_pkg::pvd_cnt_type       cnt;
    logic                       seen_low;
    logic                       detector_enable;
    logic                       detect_source_select;
    logic                       detect_action_select;
    logic [3:0]                 detect_level_select;
    logic                       low_level_flag;
    logic                       lowvolt_reset_source_flag;
    logic                       lvi_rst;
    logic                       rst_out;
    logic                       irq_pulse;
    logic                       irq_level;
    logic [7:0]                 rdata;
    logic                       rvalid;
  } pvd_top_state_type;

  localparam pvd_top_state_type ST_RESET = '{
    poweron_clear:                       pvd_pkg::PVD_POC_HOLD,
    cnt:                       '0,
    seen_low:                  1'b0,
    detector_enable:           pvd_pkg::PVD_CTRL_RESET[pvd_pkg::PVD_CTRL_EN_BIT],
    detect_source_select:      pvd_pkg::PVD_CTRL_RESET[pvd_pkg::PVD_CTRL_SEL_BIT],
    detect_action_select:      pvd_pkg::PVD_CTRL_RESET[pvd_pkg::PVD_CTRL_ACT_BIT],
    detect_level_select:       pvd_pkg::PVD_LEVEL_RESET,
    low_level_flag:            1'b0,
    lowvolt_reset_source_flag: 1'b0,
    lvi_rst:                   1'b0,
    rst_out:                   1'b1,
    irq_pulse:                 1'b0,
    irq_level:                 1'b0,
    rdata:                     pvd_pkg::PVD_RDATA_RESET,
    rvalid:                    1'b0
  };

  // ----------------------------------------------------------------
  // Comparator synchronisers
  // ----------------------------------------------------------------
  logic [NSYNC-1:0] raw_vec;
  logic [NSYNC-1:0] lvl_vec;

  assign raw_vec = {i_poweron_threshold_mode, i_ext_pin_above_detect,
                    i_supply_above_detect, i_supply_above_poc_upper,
                    i_supply_above_poc_low};

  pvd_sync_if sif [NSYNC] ();

  for (genvar g = 0; g < NSYNC; g++)
  begin : g_sync
    assign sif[g].raw = raw_vec[g];
    assign lvl_vec[g] = sif[g].level;
    pvd_sync u_sync (
      .i_clk_sys (i_clk_sys),
      .i_reset   (i_reset),
      .i_ce      (i_ce),
      .sif       (sif[g])
    );
  end

  logic poc_low_ok;
  logic poc_upper_ok;
  logic sup_ok;
  logic ext_ok;
  logic dual_mode;

  assign poc_low_ok   = lvl_vec[0];
  assign poc_upper_ok = lvl_vec[1];
  assign sup_ok       = lvl_vec[2];
  assign ext_ok       = lvl_vec[3];
  assign dual_mode    = lvl_vec[4];

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  pvd_top_state_type st_ff;
  pvd_top_state_type nxt_st;

  always_comb
  begin
    logic [7:0] cur_ctrl;
    logic [7:0] wr_byte;
    logic       wr_any;
    logic       below;
    logic       poc_clear;
    cur_ctrl = 8'h00;
    wr_byte  = 8'h00;
    wr_any   = 1'b0;
    below    = 1'b0;
    poc_clear = 1'b0;
    nxt_st   = st_ff;

    // Power-on-clear sequencing
    case (st_ff.poweron_clear)
      pvd_pkg::PVD_POC_HOLD:
      begin
        if (!poc_low_ok)
        begin
          nxt_st.cnt      = '0;
          nxt_st.seen_low = 1'b1;
        end
        else if (!dual_mode)
        begin
          nxt_st.poweron_clear = pvd_pkg::PVD_POC_RUN; // [R1]
        end
        else if (poc_upper_ok)
        begin
          nxt_st.cnt = '0;
          // Slow rises have had their settling time already
          if (st_ff.seen_low &&
              st_ff.cnt < pvd_pkg::pvd_cnt_type'(SHORT_WINDOW_CYC))
          begin
            nxt_st.poweron_clear = pvd_pkg::PVD_POC_STAB; // [R3]
          end
          else
          begin
            nxt_st.poweron_clear = pvd_pkg::PVD_POC_RUN; // [R2]
          end
        end
        else if (st_ff.cnt != '1)
        begin
          nxt_st.cnt = st_ff.cnt + 1'b1;
        end
      end
      pvd_pkg::PVD_POC_STAB:
      begin
        if (!poc_low_ok)
        begin
          nxt_st.poweron_clear = pvd_pkg::PVD_POC_HOLD;
          nxt_st.cnt = '0;
        end
        else if (st_ff.cnt >= pvd_pkg::pvd_cnt_type'(STAB_WAIT_CYC - 1))
        begin
          nxt_st.poweron_clear = pvd_pkg::PVD_POC_RUN; // [R3]
          nxt_st.cnt = '0;
        end
        else
        begin
          nxt_st.cnt = st_ff.cnt + 1'b1;
        end
      end
      pvd_pkg::PVD_POC_RUN:
      begin
        if (!poc_low_ok)
        begin
          nxt_st.poweron_clear      = pvd_pkg::PVD_POC_HOLD; // [R1] [R2]
          nxt_st.cnt      = '0;
          nxt_st.seen_low = 1'b1;
        end
        else
        begin
          nxt_st.seen_low = 1'b0;
        end
      end
      default:
      begin
        nxt_st.poweron_clear = pvd_pkg::PVD_POC_HOLD;
        nxt_st.cnt = '0;
      end
    endcase
    poc_clear = (st_ff.poweron_clear != pvd_pkg::PVD_POC_RUN);

    // ----------------------------------------------------------------
    // Register access
    // ----------------------------------------------------------------
    cur_ctrl = 8'h00;
    cur_ctrl[pvd_pkg::PVD_CTRL_EN_BIT]   = st_ff.detector_enable;
    cur_ctrl[pvd_pkg::PVD_CTRL_SEL_BIT]  = st_ff.detect_source_select;
    cur_ctrl[pvd_pkg::PVD_CTRL_ACT_BIT]  = st_ff.detect_action_select;
    cur_ctrl[pvd_pkg::PVD_CTRL_FLAG_BIT] = st_ff.low_level_flag; // [R9]

    wr_any  = i_reg_wr | i_reg_bit_wr;
    wr_byte = i_reg_wdata;
    if (i_reg_bit_wr)
    begin
      wr_byte = (i_reg_addr == pvd_pkg::PVD_ADDR_LEVEL) ?
                {4'h0, st_ff.detect_level_select} : cur_ctrl;
      wr_byte[i_reg_bit_idx] = i_reg_bit_val;
    end

    if (wr_any && i_reg_addr == pvd_pkg::PVD_ADDR_CTRL)
    begin
      // Flag bit and bits 6..3 are not writable
      nxt_st.detector_enable      = wr_byte[pvd_pkg::PVD_CTRL_EN_BIT];  // [R12]
      nxt_st.detect_source_select = wr_byte[pvd_pkg::PVD_CTRL_SEL_BIT]; // [R11]
      nxt_st.detect_action_select = wr_byte[pvd_pkg::PVD_CTRL_ACT_BIT]; // [R11]
    end
    if (wr_any && i_reg_addr == pvd_pkg::PVD_ADDR_LEVEL)
    begin
      nxt_st.detect_level_select = wr_byte[3:0]; // [R7]
    end

    nxt_st.rvalid = i_reg_rd;
    if (i_reg_rd)
    begin
      case (i_reg_addr)
        pvd_pkg::PVD_ADDR_CTRL:   nxt_st.rdata = cur_ctrl;
        pvd_pkg::PVD_ADDR_LEVEL:  nxt_st.rdata = {4'h0, st_ff.detect_level_select};
        pvd_pkg::PVD_ADDR_RSTSRC: nxt_st.rdata = {7'h00, st_ff.lowvolt_reset_source_flag};
        default:                  nxt_st.rdata = 8'h00;
      endcase
      if (i_reg_addr == pvd_pkg::PVD_ADDR_RSTSRC)
      begin
        nxt_st.lowvolt_reset_source_flag = 1'b0;
      end
    end

    // ----------------------------------------------------------------
    // Detector, no stop-mode gating so it runs in stop too [R8]
    // ----------------------------------------------------------------
    below = st_ff.detect_source_select ? !ext_ok : !sup_ok; // [R4]
    nxt_st.low_level_flag = st_ff.detector_enable & below;  // [R14] [R9]
    nxt_st.lvi_rst  = st_ff.detector_enable & st_ff.detect_action_select
                      & below; // [R5]
    nxt_st.irq_level = st_ff.detector_enable & !st_ff.detect_action_select
                       & st_ff.low_level_flag; // [R15]
    nxt_st.irq_pulse = st_ff.detector_enable & !st_ff.detect_action_select
                       & (nxt_st.low_level_flag != st_ff.low_level_flag); // [R6]

    // Set wins over the read-clear
    if (nxt_st.lvi_rst && !st_ff.lvi_rst)
    begin
      nxt_st.lowvolt_reset_source_flag = 1'b1; // [R10]
    end

    // Power-on and watchdog resets clear control, detector reset does not
    if (poc_clear || i_wdt_reset)
    begin
      nxt_st.detector_enable      = 1'b0; // [R13]
      nxt_st.detect_source_select = 1'b0; // [R13]
      nxt_st.detect_action_select = 1'b0; // [R13]
      nxt_st.detect_level_select  = pvd_pkg::PVD_LEVEL_RESET;
      nxt_st.low_level_flag       = 1'b0;
      nxt_st.lvi_rst              = 1'b0;
      nxt_st.irq_pulse            = 1'b0;
      nxt_st.irq_level            = 1'b0;
    end
    if (poc_clear)
    begin
      nxt_st.lowvolt_reset_source_flag = 1'b0;
    end

    nxt_st.rst_out = (nxt_st.poweron_clear != pvd_pkg::PVD_POC_RUN) | nxt_st.lvi_rst;
  end

  // Reset is honoured even while the clock enable is low
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      st_ff <= ST_RESET;
    end
    else if (i_ce)
    begin
      st_ff <= nxt_st;
    end
  end

  assign o_reg_rdata            = st_ff.rdata;
  assign o_reg_rvalid           = st_ff.rvalid;
  assign o_internal_reset       = st_ff.rst_out;
  assign o_low_voltage_irq      = st_ff.irq_pulse;
  assign o_irq_request          = st_ff.irq_level;
  assign o_detector_enable      = st_ff.detector_enable;
  assign o_detect_source_select = st_ff.detect_source_select;
  assign o_detect_level_select  = st_ff.detect_level_select;

endmodule : pvd_top

// *** sim/pvd_comp_model.sv ***
// Behavioural comparators for the supply, detect levels and the external pin
`timescale 1ns/1ps
module pvd_comp_model #(
  parameter logic [15:0] LOW_MV   = 16'h0636,
  parameter logic [15:0] UPPER_MV = 16'h0A8C,
  parameter logic [15:0] PIN_MV   = 16'h04BA
) (
  input  wire logic [15:0] i_supply_mv,
  input  wire logic [15:0] i_pin_mv,
  input  wire logic [3:0]  i_level,
  output logic             o_above_low,
  output logic             o_above_upper,
  output logic             o_above_detect,
  output logic             o_pin_above
);
  // Sixteen detect levels in mV, highest first
  localparam logic [15:0] LEVEL_MV [16] = '{16'h1090, 16'h0FFA, 16'h0F5A, 16'h0EC4,
    16'h0E24, 16'h0D8E, 16'h0CF8, 16'h0C58, 16'h0BC2, 16'h0B22, 16'h0A8C, 16'h09F6,
    16'h0956, 16'h08C0, 16'h0820, 16'h078A};
  assign o_above_low    = i_supply_mv >= LOW_MV;
  assign o_above_upper  = i_supply_mv >= UPPER_MV;
  assign o_above_detect = i_supply_mv >= LEVEL_MV[i_level];
  assign o_pin_above    = i_pin_mv >= PIN_MV;
endmodule : pvd_comp_model

// *** sim/pvd_top_props.sv ***
// Port-level assertions for the power-on-clear and detector block
`timescale 1ns/1ps
module pvd_top_props #(
  parameter int unsigned SHORT_WINDOW_CYC = 40,
  parameter int unsigned STAB_WAIT_CYC    = 100
) (
  input wire logic        i_clk_sys,
  input wire logic        i_reset,
  input wire logic        i_ce,
  input wire logic        i_poweron_threshold_mode,
  input wire logic        i_supply_above_poc_low,
  input wire logic        i_supply_above_poc_upper,
  input wire logic        i_supply_above_detect,
  input wire logic        i_ext_pin_above_detect,
  input wire logic        i_wdt_reset,
  input wire logic [15:0] i_reg_addr,
  input wire logic        i_reg_wr,
  input wire logic        i_reg_bit_wr,
  input wire logic [2:0]  i_reg_bit_idx,
  input wire logic        i_reg_bit_val,
  input wire logic [7:0]  i_reg_wdata,
  input wire logic        i_reg_rd,
  input wire logic [7:0]  o_reg_rdata,
  input wire logic        o_reg_rvalid,
  input wire logic        o_internal_reset,
  input wire logic        o_low_voltage_irq,
  input wire logic        o_irq_request,
  input wire logic        o_detector_enable,
  input wire logic        o_detect_source_select,
  input wire logic [3:0]  o_detect_level_select
);
  // ----------------------------------------------------------------
  // Rise timing seen on the raw comparators
  // ----------------------------------------------------------------
  int unsigned low_cnt_ff;
  int unsigned up_cnt_ff;
  logic        fast_ff;
  always_ff @(posedge i_clk_sys)
  begin
    low_cnt_ff <= i_supply_above_poc_low ? low_cnt_ff + 32'h1 : 32'h0;
    up_cnt_ff  <= i_supply_above_poc_upper ? up_cnt_ff + 32'h1 : 32'h0;
    if (i_supply_above_poc_upper && up_cnt_ff == 32'h0)
    begin
      fast_ff <= low_cnt_ff < SHORT_WINDOW_CYC;
    end
  end
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_reset);
  property p_ctrl_read;
    i_reg_rd && i_ce && i_reg_addr == pvd_pkg::PVD_ADDR_CTRL && !i_reg_wr && !i_reg_bit_wr
      && !i_wdt_reset |=> o_reg_rvalid && o_reg_rdata[7] == o_detector_enable
      && o_reg_rdata[6:2] == {4'h0, o_detect_source_select};
  endproperty
  a_ctrl_read: assert property (p_ctrl_read) else $error("ctrl read mismatch");
  property p_level_read;
    i_reg_rd && i_ce && i_reg_addr == pvd_pkg::PVD_ADDR_LEVEL && !i_reg_wr && !i_reg_bit_wr
      && !i_wdt_reset |=> o_reg_rdata == {4'h0, o_detect_level_select};
  endproperty
  a_level_read: assert property (p_level_read) else $error("level read mismatch");
  property p_ctrl_write;
    i_reg_wr && i_ce && i_reg_addr == pvd_pkg::PVD_ADDR_CTRL && !o_internal_reset
      && !i_wdt_reset |=> o_detector_enable == $past(i_reg_wdata[7])
      && o_detect_source_select == $past(i_reg_wdata[2]);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("ctrl write lost");
  property p_wdt_clear;
    i_wdt_reset && i_ce |=> !o_detector_enable && o_detect_level_select == 4'h0;
  endproperty
  a_wdt_clear: assert property (p_wdt_clear) else $error("watchdog clear missed");
  property p_low_reset;
    (i_ce && !i_supply_above_poc_low) [*8] |-> o_internal_reset;
  endproperty
  a_low_reset: assert property (p_low_reset) else $error("no reset below low");
  property p_dual_release;
    $fell(o_internal_reset) && i_poweron_threshold_mode |-> $past(i_supply_above_poc_upper, 3);
  endproperty
  a_dual_release: assert property (p_dual_release) else $error("early dual release");
  property p_stab_wait;
    $fell(o_internal_reset) && i_poweron_threshold_mode && fast_ff |-> up_cnt_ff >= STAB_WAIT_CYC;
  endproperty
  a_stab_wait: assert property (p_stab_wait) else $error("wait too short");
  property p_disabled_quiet;
    (!o_detector_enable) [*5] |-> !o_irq_request && !o_low_voltage_irq;
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet) else $error("irq while off");
  property p_rise_irq;
    $rose(i_supply_above_detect) && o_irq_request && o_detector_enable && !o_detect_source_select
      |-> ##[3:7] o_low_voltage_irq;
  endproperty
  a_rise_irq: assert property (p_rise_irq) else $error("no irq on rise");
  c_fast_release: cover property ($fell(o_internal_reset) && fast_ff);
  c_irq_pulse: cover property (o_low_voltage_irq);
  c_lvi_reset: cover property (o_detector_enable && o_internal_reset);
endmodule : pvd_top_props

// *** sim/pvd_top_tb.sv ***
// Self-checking bench for the power-on-clear and detector block
`timescale 1ns/1ps
module pvd_top_tb;
  localparam logic [15:0] CTRL = pvd_pkg::PVD_ADDR_CTRL;
  localparam logic [15:0] LVL  = pvd_pkg::PVD_ADDR_LEVEL;
  localparam logic [15:0] SRC  = pvd_pkg::PVD_ADDR_RSTSRC;
  logic        i_clk_sys = 1'b0, i_reset = 1'b1, i_ce = 1'b1, i_poweron_threshold_mode = 1'b0;
  logic        i_supply_above_poc_low, i_supply_above_poc_upper;
  logic        i_supply_above_detect, i_ext_pin_above_detect;
  logic        i_wdt_reset = 1'b0, i_reg_wr = 1'b0, i_reg_bit_wr = 1'b0, i_reg_rd = 1'b0;
  logic        i_reg_bit_val = 1'b0;
  logic [2:0]  i_reg_bit_idx = 3'h0;
  logic [7:0]  i_reg_wdata = 8'h00, o_reg_rdata;
  logic [15:0] i_reg_addr = 16'h0000, supply_mv = 16'h0000, pin_mv = 16'h0FFF;
  logic        o_reg_rvalid, o_internal_reset, o_low_voltage_irq, o_irq_request;
  logic        o_detector_enable, o_detect_source_select;
  logic [3:0]  o_detect_level_select;
  int          fails = 0, checks_done = 0, cycles = 0, pulses = 0;
  pvd_comp_model MDL (.i_supply_mv(supply_mv), .i_pin_mv(pin_mv), .i_level(o_detect_level_select),
    .o_above_low(i_supply_above_poc_low), .o_above_upper(i_supply_above_poc_upper),
    .o_above_detect(i_supply_above_detect), .o_pin_above(i_ext_pin_above_detect));
  pvd_top #(.SHORT_WINDOW_CYC(40), .STAB_WAIT_CYC(100)) DUT (.i_clk_sys, .i_reset, .i_ce,
    .i_poweron_threshold_mode, .i_supply_above_poc_low, .i_supply_above_poc_upper,
    .i_supply_above_detect, .i_ext_pin_above_detect, .i_wdt_reset, .i_reg_addr, .i_reg_wr,
    .i_reg_bit_wr, .i_reg_bit_idx, .i_reg_bit_val, .i_reg_wdata, .i_reg_rd, .o_reg_rdata,
    .o_reg_rvalid, .o_internal_reset, .o_low_voltage_irq, .o_irq_request, .o_detector_enable,
    .o_detect_source_select, .o_detect_level_select);
  always #2.5 i_clk_sys = ~i_clk_sys;
  always @(posedge i_clk_sys)
  begin
    pulses = pulses + (o_low_voltage_irq === 1'b1);
    cycles++;
    if (cycles == 5000)
    begin
      fails++;
      close_out();
    end
  end
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  function automatic logic [7:0] b(input logic x);
    return {7'h00, x};
  endfunction : b
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk_sys);
    #1;
  endtask : tick
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    i_reg_addr = a;
    i_reg_wdata = d;
    i_reg_wr = 1'b1;
    tick(1);
    i_reg_wr = 1'b0;
    tick(1);
  endtask : wr
  task automatic bw(input logic [15:0] a, input logic [2:0] idx, input logic v);
    i_reg_addr = a;
    i_reg_bit_idx = idx;
    i_reg_bit_val = v;
    i_reg_bit_wr = 1'b1;
    tick(1);
    i_reg_bit_wr = 1'b0;
    tick(1);
  endtask : bw
  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    i_reg_addr = a;
    i_reg_rd = 1'b1;
    tick(1);
    i_reg_rd = 1'b0;
    chk("rvalid", 8'h01, b(o_reg_rvalid));
    chk("rdata", exp, o_reg_rdata);
    tick(1);
  endtask : rd
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic s_single;
    chk("poc reset", 8'h01, b(o_internal_reset));
    supply_mv = 16'h07D0;
    tick(12);
    chk("poc release", 8'h00, b(o_internal_reset));
    supply_mv = 16'h03E8;
    tick(12);
    chk("poc reassert", 8'h01, b(o_internal_reset));
  endtask : s_single
  task automatic s_dual;
    i_poweron_threshold_mode = 1'b1;
    i_reset = 1'b1;
    tick(3);
    i_reset = 1'b0;
    supply_mv = 16'h07D0;
    tick(20);
    chk("low only", 8'h01, b(o_internal_reset));
    supply_mv = 16'h0BB8;
    tick(60);
    chk("stab wait", 8'h01, b(o_internal_reset));
    tick(60);
    chk("stab done", 8'h00, b(o_internal_reset));
    supply_mv = 16'h03E8;
    tick(12);
    chk("dual drop", 8'h01, b(o_internal_reset));
    supply_mv = 16'h07D0;
    tick(60);
    supply_mv = 16'h0BB8;
    tick(12);
    chk("slow rise", 8'h00, b(o_internal_reset));
  endtask : s_dual
  task automatic s_regs;
    rd(CTRL, 8'h00);
    wr(CTRL, 8'hFF);
    rd(CTRL, 8'h86);
    bw(CTRL, 3'h7, 1'b0);
    bw(CTRL, 3'h0, 1'b1);
    rd(CTRL, 8'h06);
    wr(LVL, 8'hFF);
    rd(LVL, 8'h0F);
    // Clock enable low must swallow the write
    i_ce = 1'b0;
    wr(LVL, 8'h03);
    i_ce = 1'b1;
    rd(LVL, 8'h0F);
    bw(LVL, 3'h1, 1'b0);
    rd(LVL, 8'h0D);
    rd(16'h0000, 8'h00);
    rd(SRC, 8'h00);
  endtask : s_regs
  task automatic s_irq;
    int base;
    supply_mv = 16'h1388;
    wr(LVL, 8'h00);
    wr(CTRL, 8'h80);
    tick(8);
    rd(CTRL, 8'h80);
    for (int i = 0; i < 2; i++)
    begin
      supply_mv = (i == 0) ? 16'h0FA0 : 16'h1388;
      base = pulses;
      tick(12);
      chk("irq pulses", 8'h01, 8'(pulses - base));
      chk("irq level", b(i == 0), b(o_irq_request));
    end
    rd(CTRL, 8'h80);
    wr(LVL, 8'h0F);
    supply_mv = 16'h0FA0;
    tick(12);
    rd(CTRL, 8'h80);
    pin_mv = 16'h03E8;
    wr(CTRL, 8'h84);
    tick(8);
    rd(CTRL, 8'h85);
    wr(CTRL, 8'h00);
    tick(8);
    chk("irq off", 8'h00, b(o_irq_request));
    rd(CTRL, 8'h00);
    pin_mv = 16'h0FFF;
  endtask : s_irq
  task automatic s_lvi_reset;
    wr(LVL, 8'h00);
    wr(CTRL, 8'h82);
    tick(10);
    chk("lvi reset", 8'h01, b(o_internal_reset));
    supply_mv = 16'h1388;
    tick(10);
    chk("lvi release", 8'h00, b(o_internal_reset));
    rd(SRC, 8'h01);
    rd(SRC, 8'h00);
    rd(CTRL, 8'h82);
    // Non-zero level so the watchdog clear is visible
    wr(LVL, 8'h05);
    rd(LVL, 8'h05);
    i_wdt_reset = 1'b1;
    tick(1);
    i_wdt_reset = 1'b0;
    rd(CTRL, 8'h00);
    rd(LVL, 8'h00);
  endtask : s_lvi_reset
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : close_out
  initial
  begin
    tick(3);
    i_reset = 1'b0;
    s_single();
    s_dual();
    s_regs();
    s_irq();
    s_lvi_reset();
    close_out();
  end
endmodule : pvd_top_tb
bind pvd_top pvd_top_props #(.SHORT_WINDOW_CYC(SHORT_WINDOW_CYC), .STAB_WAIT_CYC(STAB_WAIT_CYC))
  u_props (.i_clk_sys, .i_reset, .i_ce, .i_poweron_threshold_mode, .i_supply_above_poc_low,
  .i_supply_above_poc_upper, .i_supply_above_detect, .i_ext_pin_above_detect, .i_wdt_reset,
  .i_reg_addr, .i_reg_wr, .i_reg_bit_wr, .i_reg_bit_idx, .i_reg_bit_val, .i_reg_wdata, .i_reg_rd,
  .o_reg_rdata, .o_reg_rvalid, .o_internal_reset, .o_low_voltage_irq, .o_irq_request,
  .o_detector_enable, .o_detect_source_select, .o_detect_level_select);
